// file: include/pmus_defines.svh
// timing counts and field positions for the five-channel supervisor
// assumes pclk is the switching oscillator clock
`ifndef PMUS_DEFINES_SVH
`define PMUS_DEFINES_SVH

// -----------------------------------------------------------------
// soft-start and fault timing, in oscillator cycles
// -----------------------------------------------------------------
`define PMUS_SS_LONG_CYC   13'h1000
`define PMUS_SS_BUCK_CYC   13'h0800
`define PMUS_FAULT_CYC     17'h186A0

// -----------------------------------------------------------------
// channel indices
// -----------------------------------------------------------------
`define PMUS_CH_BOOST      0
`define PMUS_CH_MAIN       1
`define PMUS_CH_BUCK       2
`define PMUS_CH_AUX_CONTROLLER_A       3
`define PMUS_CH_AUX_CONTROLLER_B       4

// -----------------------------------------------------------------
// apb register offsets and reset values
// -----------------------------------------------------------------
`define PMUS_ADDR_STATUS   12'h000
`define PMUS_ADDR_IRQ      12'h004
`define PMUS_ADDR_MASK     12'h008
`define PMUS_ADDR_CTRL     12'h00C
`define PMUS_MASK_RST      32'h00000000
`define PMUS_CTRL_RST      32'h00000000

// interrupt status bits
`define PMUS_IRQ_FAULT     0
`define PMUS_IRQ_UVLO      1
`define PMUS_IRQ_BUCKOK    2
`define PMUS_IRQ_W         3

`endif

// file: include/pmus_pkg.sv
// types shared by the supervisor files
package pmus_pkg;

  typedef enum logic [3:0] {
    PMUS_OFF    = 4'b0001,
    PMUS_BOOST  = 4'b0010,
    PMUS_RUN    = 4'b0100,
    PMUS_LATCH  = 4'b1000
  } pmus_state_e;

  typedef logic [4:0] pmus_chan_t;

endpackage : pmus_pkg

// file: hw/pmus_softstart.sv
// one channel soft-start ramp counter
// assumes enable is already gated by sequencing and fault state
`timescale 1ns/1ps
`include "pmus_defines.svh"

module pmus_softstart #(
  parameter logic [12:0] RAMP_CYC = `PMUS_SS_LONG_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        enable,
  output logic [12:0]      ramp_r,
  output logic             done_r
);

  // restart from zero whenever enable drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_r <= 13'h0000;
    end else if (!enable) begin
      ramp_r <= 13'h0000;
    end else if (ramp_r != RAMP_CYC) begin
      ramp_r <= ramp_r + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= enable && (ramp_r == RAMP_CYC);
    end
  end

endmodule : pmus_softstart

// file: hw/pmus_fault_timer.sv
// out-of-regulation persistence timer
// assumes oor is already qualified per channel
`timescale 1ns/1ps
`include "pmus_defines.svh"

module pmus_fault_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clear,
  input  wire logic        oor,
  output logic             expired_r
);

  logic [16:0] count_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 17'h00000;
    end else if (clear || !oor) begin
      count_r <= 17'h00000;
    end else if (count_r != `PMUS_FAULT_CYC) begin
      count_r <= count_r + 17'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired_r <= 1'b0;
    end else begin
      expired_r <= !clear && oor && (count_r == `PMUS_FAULT_CYC - 17'h00001);
    end
  end

endmodule : pmus_fault_timer

// file: hw/pmus_supervisor.sv
// top of the five-channel power supervisor: sequencing, soft-start,
// fault latch, open-drain status pins and an apb register slave
// assumes pclk is the oscillator clock and all pins are synchronous
`timescale 1ns/1ps
`include "pmus_defines.svh"

module pmus_supervisor (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        boost_enable_in,
  input  wire logic        main_enable_in,
  input  wire logic        buck_enable_in,
  input  wire logic        aux_a_enable_in,
  input  wire logic        aux_b_enable_in,
  input  wire logic        main_topology_select,
  input  wire logic        aux_b_topology_select,
  input  wire logic [4:0]  chan_in_reg,
  input  wire logic        boost_uvlo,
  input  wire logic        main_dropout,
  input  wire logic        thermal_limit,
  output logic [4:0]       chan_on_r,
  output logic [12:0]      main_ref_r,
  output logic [12:0]      buck_ref_r,
  output logic [12:0]      aux_a_ref_r,
  output logic [12:0]      aux_b_ref_r,
  output logic             aux_duty_limit_r,
  output logic             buck_ok_n_o,
  output logic             buck_ok_n_oe,
  output logic             aux_b_power_good_o,
  output logic             aux_b_power_good_oe,
  output logic             fault_flag_out_o,
  output logic             fault_flag_out_oe,
  output logic             irq
);

  // -----------------------------------------------------------------
  // sequencing state
  // -----------------------------------------------------------------
  pmus_pkg::pmus_state_e state_r;
  pmus_pkg::pmus_state_e state_nxt;
  logic                  boost_en_d_r;
  logic                  boost_rise;
  logic                  fault_exp;
  logic                  latched;
  pmus_pkg::pmus_chan_t  want;
  pmus_pkg::pmus_chan_t  ss_en;
  pmus_pkg::pmus_chan_t  ss_done;
  pmus_pkg::pmus_chan_t  oor_q;
  logic [12:0]           ramp [1:4];
  logic                  oor_any;
  logic [31:0]           mask_r;
  logic [31:0]           ctrl_r;
  logic [`PMUS_IRQ_W-1:0] irq_stat_r;
  logic [`PMUS_IRQ_W-1:0] irq_set;
  logic                  buck_ok_r;
  logic                  buck_ok_d_r;
  logic                  boost_reg;

  assign boost_rise = boost_enable_in && !boost_en_d_r;
  assign boost_reg  = chan_in_reg[`PMUS_CH_BOOST] && !boost_uvlo;
  assign latched    = (state_r == pmus_pkg::PMUS_LATCH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_en_d_r <= 1'b0;
    end else begin
      boost_en_d_r <= boost_enable_in;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pmus_pkg::PMUS_OFF: begin
        if (boost_enable_in) begin
          state_nxt = pmus_pkg::PMUS_BOOST;
        end
      end
      pmus_pkg::PMUS_BOOST: begin
        if (!boost_enable_in) begin
          state_nxt = pmus_pkg::PMUS_OFF;
        end else if (boost_reg) begin
          state_nxt = pmus_pkg::PMUS_RUN;
        end
      end
      pmus_pkg::PMUS_RUN: begin
        if (!boost_enable_in) begin
          state_nxt = pmus_pkg::PMUS_OFF;
        end else if (fault_exp) begin
          state_nxt = pmus_pkg::PMUS_LATCH;
        end else if (boost_uvlo) begin
          state_nxt = pmus_pkg::PMUS_BOOST;
        end
      end
      pmus_pkg::PMUS_LATCH: begin
        // only a fresh boost enable edge leaves latch-off; a held level does not
        if (boost_rise) begin
          state_nxt = pmus_pkg::PMUS_BOOST;
        end
      end
      default: state_nxt = pmus_pkg::PMUS_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pmus_pkg::PMUS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // -----------------------------------------------------------------
  // channel enables and soft-start
  // -----------------------------------------------------------------
  // software may hold any non-boost channel off through ctrl bits 4:1
  // aux-b topology pin only steers the analog stage; no logic here reads it
  always_comb begin
    want = 5'h00;
    want[`PMUS_CH_BOOST] = boost_enable_in && (state_r == pmus_pkg::PMUS_BOOST
                           || state_r == pmus_pkg::PMUS_RUN);
    if (state_r == pmus_pkg::PMUS_RUN) begin
      want[`PMUS_CH_MAIN] = main_enable_in && !ctrl_r[1];
      want[`PMUS_CH_BUCK] = buck_enable_in && !ctrl_r[2];
      want[`PMUS_CH_AUX_CONTROLLER_A] = aux_a_enable_in && !ctrl_r[3];
      want[`PMUS_CH_AUX_CONTROLLER_B] = aux_b_enable_in && !ctrl_r[4];
    end
  end

  // enable drops in latch-off, so each ramp restarts on recovery
  assign ss_en = want;
  assign ss_done[`PMUS_CH_BOOST] = boost_reg;

  // buck ramp is half length so buck and main rise at a similar slope
  genvar g;
  generate
    for (g = 1; g < 5; g++) begin : g_ss
      pmus_softstart #(
        .RAMP_CYC ((g == `PMUS_CH_BUCK) ? `PMUS_SS_BUCK_CYC : `PMUS_SS_LONG_CYC)
      ) u_ss (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (ss_en[g]),
        .ramp_r  (ramp[g]),
        .done_r  (ss_done[g])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_on_r   <= 5'h00;
      main_ref_r  <= 13'h0000;
      buck_ref_r  <= 13'h0000;
      aux_a_ref_r <= 13'h0000;
      aux_b_ref_r <= 13'h0000;
    end else begin
      chan_on_r   <= (latched || boost_uvlo) ? 5'h00 : want;
      main_ref_r  <= ramp[`PMUS_CH_MAIN];
      buck_ref_r  <= ramp[`PMUS_CH_BUCK];
      aux_a_ref_r <= ramp[`PMUS_CH_AUX_CONTROLLER_A];
      aux_b_ref_r <= ramp[`PMUS_CH_AUX_CONTROLLER_B];
    end
  end

  // duty limiter on while either aux channel is wanted: the analog loop caps at its 80 percent floor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_duty_limit_r <= 1'b0;
    end else begin
      aux_duty_limit_r <= want[`PMUS_CH_AUX_CONTROLLER_A] || want[`PMUS_CH_AUX_CONTROLLER_B];
    end
  end

  // -----------------------------------------------------------------
  // fault detection
  // -----------------------------------------------------------------
  // only channels running past soft-start are watched
  always_comb begin
    oor_q = 5'h00;
    for (int i = 1; i < 5; i++) begin
      oor_q[i] = want[i] && ss_done[i] && !chan_in_reg[i];
    end
    if (want[`PMUS_CH_MAIN] && ss_done[`PMUS_CH_MAIN] && !main_topology_select
        && main_dropout) begin
      oor_q[`PMUS_CH_MAIN] = 1'b1;
    end
  end

  assign oor_any = |oor_q;

  // timer clears outside run, so a uvlo restart never inherits a partial count
  pmus_fault_timer u_ft (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (state_r != pmus_pkg::PMUS_RUN),
    .oor       (oor_any),
    .expired_r (fault_exp)
  );

  // -----------------------------------------------------------------
  // status pins
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_ok_r <= 1'b0;
    end else begin
      // the enable term drops buck ok at shutdown, not only once the
      // done flag clears a cycle later with the ramp already at zero
      buck_ok_r <= ss_done[`PMUS_CH_BUCK] && want[`PMUS_CH_BUCK] && !latched && !thermal_limit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_ok_n_o         <= 1'b0;
      buck_ok_n_oe        <= 1'b0;
      aux_b_power_good_o  <= 1'b0;
      aux_b_power_good_oe <= 1'b0;
      fault_flag_out_o    <= 1'b0;
      fault_flag_out_oe   <= 1'b0;
    end else begin
      buck_ok_n_o         <= 1'b0;
      buck_ok_n_oe        <= buck_ok_r;
      aux_b_power_good_o  <= 1'b0;
      // open drain: pulled low while not good, released when good
      aux_b_power_good_oe <= !(ss_done[`PMUS_CH_AUX_CONTROLLER_B] && chan_in_reg[`PMUS_CH_AUX_CONTROLLER_B]);
      fault_flag_out_o    <= 1'b0;
      fault_flag_out_oe   <= !latched;
    end
  end

  // -----------------------------------------------------------------
  // interrupts
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_ok_d_r <= 1'b0;
    end else begin
      buck_ok_d_r <= buck_ok_r;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[`PMUS_IRQ_FAULT]  = fault_exp;
    irq_set[`PMUS_IRQ_UVLO]   = boost_uvlo && (state_r == pmus_pkg::PMUS_RUN);
    irq_set[`PMUS_IRQ_BUCKOK] = buck_ok_r && !buck_ok_d_r;
  end

  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // set wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else if (wr_acc && paddr == `PMUS_ADDR_IRQ) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[`PMUS_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & mask_r[`PMUS_IRQ_W-1:0]);
    end
  end

  // -----------------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `PMUS_MASK_RST;
      ctrl_r <= `PMUS_CTRL_RST;
    end else if (wr_acc) begin
      if (paddr == `PMUS_ADDR_MASK) begin
        mask_r <= {29'h0, pwdata[`PMUS_IRQ_W-1:0]};
      end
      if (paddr == `PMUS_ADDR_CTRL) begin
        ctrl_r <= {27'h0, pwdata[4:1], 1'b0};
      end
    end
  end

  // no wait state: data registered in setup, ready in the first access cycle
  // reads decode in setup so prdata stands through the whole access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `PMUS_ADDR_STATUS || paddr == `PMUS_ADDR_IRQ
                 || paddr == `PMUS_ADDR_MASK || paddr == `PMUS_ADDR_CTRL);
      if (rd_acc) begin
        case (paddr)
          `PMUS_ADDR_STATUS: prdata <= {21'h0, state_r, chan_on_r, latched, buck_ok_r};
          `PMUS_ADDR_IRQ:    prdata <= {29'h0, irq_stat_r};
          `PMUS_ADDR_MASK:   prdata <= mask_r;
          `PMUS_ADDR_CTRL:   prdata <= ctrl_r;
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : pmus_supervisor

// file: testbench/pmus_supervisor_properties.sv
// pin-level assertions for the supervisor top
// bound to every pmus_supervisor instance, one clock domain
`timescale 1ns/1ps
module pmus_supervisor_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        boost_enable_in,
  input wire logic [4:0]  chan_in_reg,
  input wire logic        boost_uvlo,
  input wire logic        thermal_limit,
  input wire logic [4:0]  chan_on_r,
  input wire logic [12:0] main_ref_r,
  input wire logic [12:0] buck_ref_r,
  input wire logic [12:0] aux_b_ref_r,
  input wire logic        buck_ok_n_oe,
  input wire logic        aux_b_power_good_oe,
  input wire logic        fault_flag_out_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_main_cap;
    main_ref_r <= 13'h1000;
  endproperty
  a_main_cap: assert property (p_main_cap) else $error("main ramp above full");
  property p_buck_cap;
    buck_ref_r <= 13'h0800;
  endproperty
  a_buck_cap: assert property (p_buck_cap) else $error("buck ramp above full");
  property p_boost_fast;
    $rose(boost_enable_in) && !boost_uvlo |-> ##[1:3] chan_on_r[0];
  endproperty
  a_boost_fast: assert property (p_boost_fast) else $error("boost not on at once");
  property p_ok_after_ramp;
    buck_ok_n_oe |-> buck_ref_r == 13'h0800;
  endproperty
  a_ok_after_ramp: assert property (p_ok_after_ramp) else $error("buck ok before ramp end");
  property p_ok_thermal;
    thermal_limit [*3] |-> !buck_ok_n_oe;
  endproperty
  a_ok_thermal: assert property (p_ok_thermal) else $error("buck ok held in thermal");
  property p_flag_off;
    !fault_flag_out_oe |-> ##[0:2] chan_on_r == 5'h00;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag released with channels on");
  property p_buck_after_boost;
    $rose(chan_on_r[2]) |-> chan_on_r[0];
  endproperty
  a_buck_after_boost: assert property (p_buck_after_boost) else $error("buck on without boost");
  property p_aux_controller_b_good;
    $fell(aux_b_power_good_oe) |-> $past(chan_in_reg[4]) && aux_b_ref_r == 13'h1000;
  endproperty
  a_aux_controller_b_good: assert property (p_aux_controller_b_good) else $error("aux b good too early");
  property p_uvlo_off;
    boost_uvlo |=> chan_on_r == 5'h00;
  endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("channels on in undervoltage");
  property p_ramp_restart;
    $rose(chan_on_r[1]) |-> main_ref_r < 13'h0004;
  endproperty
  a_ramp_restart: assert property (p_ramp_restart) else $error("main ramp not from zero");
endmodule : pmus_supervisor_properties

bind pmus_supervisor pmus_supervisor_properties i_props (
  .pclk                (pclk),
  .presetn             (presetn),
  .boost_enable_in     (boost_enable_in),
  .chan_in_reg         (chan_in_reg),
  .boost_uvlo          (boost_uvlo),
  .thermal_limit       (thermal_limit),
  .chan_on_r           (chan_on_r),
  .main_ref_r          (main_ref_r),
  .buck_ref_r          (buck_ref_r),
  .aux_b_ref_r         (aux_b_ref_r),
  .buck_ok_n_oe        (buck_ok_n_oe),
  .aux_b_power_good_oe (aux_b_power_good_oe),
  .fault_flag_out_oe   (fault_flag_out_oe)
);

// file: testbench/pmus_chan_model.sv
// behavioural converter channels facing the supervisor
// a channel regulates once enabled and its ramp is at full scale
`timescale 1ns/1ps
module pmus_chan_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        boost_enable_in,
  input  wire logic [4:0]  chan_on_r,
  input  wire logic [12:0] main_ref_r,
  input  wire logic [12:0] buck_ref_r,
  input  wire logic [12:0] aux_a_ref_r,
  input  wire logic [12:0] aux_b_ref_r,
  input  wire logic [4:0]  fail,
  output logic [4:0]       chan_in_reg
);
  logic [4:0] done;
  // boost starts on its own, so only its enable matters here
  assign done = {aux_b_ref_r == 13'h1000, aux_a_ref_r == 13'h1000, buck_ref_r == 13'h0800,
                 main_ref_r == 13'h1000, 1'b1};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_in_reg <= 5'h00;
    end else begin
      chan_in_reg <= {chan_on_r[4:1], boost_enable_in} & done & ~fail;
    end
  end
endmodule : pmus_chan_model

// file: testbench/multi_channel_pmu_supervisor_bench.sv
// self-checking bench for the five-channel supervisor
// open-drain pins resolved here with pull-ups
`timescale 1ns/1ps
`include "pmus_defines.svh"
module multi_channel_pmu_supervisor_bench;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, aux_duty_limit_r;
  logic        boost_enable_in, main_enable_in, buck_enable_in, aux_a_enable_in, aux_b_enable_in;
  logic        main_topology_select, aux_b_topology_select, boost_uvlo, main_dropout, thermal_limit;
  logic [4:0]  chan_in_reg, chan_on_r, fail;
  logic [12:0] main_ref_r, buck_ref_r, aux_a_ref_r, aux_b_ref_r;
  logic        buck_ok_n_o, buck_ok_n_oe, aux_b_power_good_o, aux_b_power_good_oe;
  logic        fault_flag_out_o, fault_flag_out_oe;
  wire         buck_ok_n, aux_b_pg, fault_flag;
  int          err_total, cmp_count, n;

  assign buck_ok_n = buck_ok_n_oe ? buck_ok_n_o : 1'b1;
  assign aux_b_pg = aux_b_power_good_oe ? aux_b_power_good_o : 1'b1;
  assign fault_flag = fault_flag_out_oe ? fault_flag_out_o : 1'b1;

  pmus_supervisor i_dut (.*);
  pmus_chan_model i_chan (.*);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // read data compared only when the access is a read
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends once pready is seen high, with no count limit of its own
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    if (!wr) chk("prdata", e, prdata);
    chk("pslverr", 32'(er), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick_n(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick_n

  initial begin
    repeat (130000) @(posedge pclk);
    err_total++;
    end_of_test();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, boost_uvlo, main_dropout, thermal_limit, fail} = '0;
    {boost_enable_in, main_enable_in, buck_enable_in, aux_a_enable_in, aux_b_enable_in} = '0;
    {main_topology_select, aux_b_topology_select} = 2'b00;
    err_total = 0;
    cmp_count = 0;
    presetn = 1'b0;
    tick_n(3);
    presetn <= 1'b1;
    apb(0, `PMUS_ADDR_STATUS, 0, 32'h00000080, 0);
    apb(0, `PMUS_ADDR_MASK, 0, `PMUS_MASK_RST, 0);
    apb(0, `PMUS_ADDR_CTRL, 0, `PMUS_CTRL_RST, 0);
    apb(1, 12'h010, 32'hFFFFFFFF, 0, 1);
    apb(0, 12'h010, 0, 32'h00000000, 1);
    $display("test registers done");
    {main_enable_in, buck_enable_in, aux_a_enable_in, aux_b_enable_in} <= 4'hF;
    tick_n(20);
    chk("chan_on no boost", 32'h0, 32'(chan_on_r));
    boost_enable_in <= 1'b1;
    n = 0;
    while (chan_on_r[2] !== 1'b1 && n < 50) begin
      tick_n(1);
      n++;
    end
    n = 0;
    while (buck_ref_r !== 13'h0800 && n < 3000) begin
      tick_n(1);
      n++;
    end
    chk("buck ramp len", 32'h1, 32'(n >= 2044 && n <= 2050));
    while (main_ref_r !== 13'h1000 && n < 5000) begin
      tick_n(1);
      n++;
    end
    chk("main ramp len", 32'h1, 32'(n >= 4092 && n <= 4100));
    tick_n(5);
    chk("buck_ok_n", 32'h0, 32'(buck_ok_n));
    chk("aux_b_pg", 32'h1, 32'(aux_b_pg));
    chk("fault_flag run", 32'h0, 32'(fault_flag));
    chk("aux_duty_limit", 32'h1, 32'(aux_duty_limit_r));
    chk("aux_a_ref", 32'h1000, 32'(aux_a_ref_r));
    thermal_limit <= 1'b1;
    tick_n(4);
    chk("buck_ok_n thermal", 32'h1, 32'(buck_ok_n));
    thermal_limit <= 1'b0;
    $display("test startup done");
    boost_uvlo <= 1'b1;
    tick_n(2);
    chk("chan_on uvlo", 32'h0, 32'(chan_on_r));
    boost_uvlo <= 1'b0;
    apb(0, `PMUS_ADDR_IRQ, 0, 32'h00000006, 0);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1, `PMUS_ADDR_MASK, 32'h00000002, 0, 0);
    tick_n(2);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1, `PMUS_ADDR_IRQ, 32'h00000006, 0, 0);
    tick_n(2);
    chk("irq cleared", 32'h0, 32'(irq));
    n = 0;
    while (main_ref_r !== 13'h1000 && n < 5000) begin
      tick_n(1);
      n++;
    end
    chk("ramp rerun", 32'h1, 32'(n > 4000));
    tick_n(5);
    $display("test uvlo and irq done");
    // aux a out of regulation after its ramp, timer must run the full count
    fail <= 5'h08;
    tick_n(50000);
    // main dropout takes over mid-count: the timer expires only if dropout counts
    {fail, main_dropout} <= {5'h00, 1'b1};
    n = 50000;
    while (chan_on_r !== 5'h00 && n < 100100) begin
      tick_n(1);
      n++;
    end
    chk("fault delay", 32'h1, 32'(n >= 100000 && n <= 100006));
    tick_n(3);
    chk("fault_flag latched", 32'h1, 32'(fault_flag));
    chk("buck_ok_n latched", 32'h1, 32'(buck_ok_n));
    apb(0, `PMUS_ADDR_IRQ, 0, 32'h00000005, 0);
    main_dropout <= 1'b0;
    tick_n(20);
    chk("latch held", 32'h0, 32'(chan_on_r));
    chk("aux_duty_limit off", 32'h0, 32'(aux_duty_limit_r));
    boost_enable_in <= 1'b0;
    tick_n(3);
    boost_enable_in <= 1'b1;
    tick_n(6);
    chk("boost back", 32'h1, 32'(chan_on_r[0]));
    $display("test fault latch done");
    end_of_test();
  end
endmodule : multi_channel_pmu_supervisor_bench
